/* File: verilog/mpoc_pkg.sv */
// Constants for the meter pulse output controller
// What this block does
// - Both outputs of a pair always share one setting.
// - One function code selects all four outputs; it resets to 95.
// - Code 73: one 5 ms pulse on pair one per four flow one pulses.
// - Code 83: one 22 ms pulse on pair one per four flow one pulses.
// - Code 80: repeat flow one on pair one, flow two on pair two, 3.9 ms.
// - Code 82: repeat flow one on pair one at 3.9 ms; pair two idle.
// - Meter-count widths: 94 is 10 ms, 95 is 32 ms, 96 is 100 ms, 93 is 250 ms.
// - Code 99: no own pulses; both pairs follow commanded states only.
// - Host commands each pair OFF or ON; OFF is open, ON is closed.
// - Controlled states saved on change, restored after reset, readable.
// - Meter type picks pair sources: heat/volume, heat/cooling, cooling/volume, volume/volume.
// - Source choice is fixed at delivery and cannot be changed later.
// - One pulse per step of the least displayed digit, set by resolution code.
// - Pulses owed are gathered per integration and sent afterwards at fixed rate.
// - Slot one outputs are the first members of each pair, slot two the second.
// - Integration runs every 2 seconds on mains supply.
// - Integration stretches to 8 seconds on backup battery.
package mpoc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Pulse widths (microseconds) and integration intervals (milliseconds) in cycles
  localparam int W_5MS_CYC       = 5000 * 1000 / CLK_PERIOD_NS;
  localparam int W_22MS_CYC      = 22000 * 1000 / CLK_PERIOD_NS;
  localparam int W_3M9_CYC       = 3900 * 1000 / CLK_PERIOD_NS;
  localparam int W_10MS_CYC      = 10000 * 1000 / CLK_PERIOD_NS;
  localparam int W_32MS_CYC      = 32000 * 1000 / CLK_PERIOD_NS;
  localparam int W_100MS_CYC     = 100000 * 1000 / CLK_PERIOD_NS;
  localparam int W_250MS_CYC     = 250000 * 1000 / CLK_PERIOD_NS;
  localparam int INTEG_MAINS_CYC = 2000 * (1000000 / CLK_PERIOD_NS);
  localparam int INTEG_BATT_CYC  = 8000 * (1000000 / CLK_PERIOD_NS);
  // Output function codes
  localparam logic [7:0] FC_DIV4_5MS   = 8'h49; // 73
  localparam logic [7:0] FC_REP_BOTH   = 8'h50; // 80
  localparam logic [7:0] FC_REP_ONE    = 8'h52; // 82
  localparam logic [7:0] FC_DIV4_22MS  = 8'h53; // 83
  localparam logic [7:0] FC_MC_250MS   = 8'h5D; // 93
  localparam logic [7:0] FC_MC_10MS    = 8'h5E; // 94
  localparam logic [7:0] FC_MC_32MS    = 8'h5F; // 95
  localparam logic [7:0] FC_MC_100MS   = 8'h60; // 96
  localparam logic [7:0] FC_CONTROLLED = 8'h63; // 99
  localparam logic [7:0] FC_RESET      = FC_MC_32MS;
  // Register indices
  localparam logic [3:0] REG_FUNC_CODE  = 4'h0;
  localparam logic [3:0] REG_RESOLUTION = 4'h1;
  localparam logic [3:0] REG_CMD_STATE  = 4'h2;
  localparam logic [3:0] REG_STATUS     = 4'h3;
  localparam logic [3:0] REG_OWED_ONE   = 4'h4;
  localparam logic [3:0] REG_OWED_TWO   = 4'h5;
  localparam logic [1:0] RES_RESET      = 2'h0;
  // Status field positions
  localparam int ST_OUT_ONE  = 0;
  localparam int ST_OUT_TWO  = 1;
  localparam int ST_BATTERY  = 2;
  localparam int ST_TYPE_LSB = 4;
  // Meter-count source selectors
  localparam logic [1:0] SRC_HEAT = 2'h0;
  localparam logic [1:0] SRC_COOL = 2'h1;
  localparam logic [1:0] SRC_VOL  = 2'h2;
  localparam int DIV_BY_FOUR = 4;
endpackage

/* File: verilog/mpoc_pair_if.sv */
// Link between the controller and one pair's pulse emitter
`timescale 1ns/1ps
interface mpoc_pair_if #(parameter int CNT_W = 16);
  logic             add_valid;
  logic [CNT_W-1:0] add_count;
  logic [31:0]      width_cyc;
  logic             clear;
  logic             pulse;
  logic [CNT_W-1:0] owed;
  modport gen (input add_valid, input add_count, input width_cyc, input clear,
               output pulse, output owed);
  modport drv (output add_valid, output add_count, output width_cyc, output clear,
               input pulse, input owed);
endinterface

/* File: verilog/mpoc_pair_gen.sv */
// Pulse emitter for one output pair: owed count drained at a fixed rate
`timescale 1ns/1ps
module mpoc_pair_gen #(
  parameter int CNT_W = 16
) (
  input  wire logic  clk_in,
  input  wire logic  rstn_in,
  mpoc_pair_if.gen   port
);
  typedef enum logic [1:0] {MPOC_IDLE, MPOC_ON, MPOC_GAP} mpoc_gen_e;

  mpoc_gen_e        state_q;
  logic [31:0]      timer_q;
  logic [CNT_W-1:0] owed_q;
  logic [CNT_W-1:0] owed_d;
  logic [CNT_W:0]   sum;
  logic             start;

  assign start = (state_q == MPOC_IDLE) && (owed_q != '0) && !port.clear;

  // Saturating add so a long backlog clips rather than wraps
  always_comb begin
    sum = {1'b0, owed_q} + {1'b0, (port.add_valid ? port.add_count : {CNT_W{1'b0}})};
    if (sum[CNT_W]) begin
      owed_d = '1;
    end else begin
      owed_d = sum[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, start};
    end
  end

  // Owed count keeps what was not sent and adds each new batch to it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      owed_q <= '0;
    end else if (port.clear) begin
      owed_q <= '0;
    end else begin
      owed_q <= owed_d;
    end
  end

  // Pulse on for one width, then off for one width plus one idle cycle: fixed frequency
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q    <= MPOC_IDLE;
      timer_q    <= '0;
      port.pulse <= 1'b0;
    end else if (port.clear) begin
      state_q    <= MPOC_IDLE;
      timer_q    <= '0;
      port.pulse <= 1'b0;
    end else begin
      case (state_q)
        MPOC_IDLE: begin
          if (start) begin
            state_q    <= MPOC_ON;
            timer_q    <= port.width_cyc - 32'h0000_0001;
            port.pulse <= 1'b1;
          end
        end
        MPOC_ON: begin
          if (timer_q == '0) begin
            state_q    <= MPOC_GAP;
            timer_q    <= port.width_cyc - 32'h0000_0001;
            port.pulse <= 1'b0;
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        MPOC_GAP: begin
          if (timer_q == '0) begin
            state_q <= MPOC_IDLE;
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q    <= MPOC_IDLE;
          port.pulse <= 1'b0;
        end
      endcase
    end
  end

  assign port.owed = owed_q;
endmodule

/* File: verilog/mpoc_top.sv */
// Meter pulse output controller: mode select, sources, batching and outputs
`timescale 1ns/1ps
module mpoc_top #(
  parameter int CNT_W           = 16,
  parameter int W_5MS_CYC       = mpoc_pkg::W_5MS_CYC,
  parameter int W_22MS_CYC      = mpoc_pkg::W_22MS_CYC,
  parameter int W_3M9_CYC       = mpoc_pkg::W_3M9_CYC,
  parameter int W_10MS_CYC      = mpoc_pkg::W_10MS_CYC,
  parameter int W_32MS_CYC      = mpoc_pkg::W_32MS_CYC,
  parameter int W_100MS_CYC     = mpoc_pkg::W_100MS_CYC,
  parameter int W_250MS_CYC     = mpoc_pkg::W_250MS_CYC,
  parameter int INTEG_MAINS_CYC = mpoc_pkg::INTEG_MAINS_CYC,
  parameter int INTEG_BATT_CYC  = mpoc_pkg::INTEG_BATT_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        flow_one_pulse_in,
  input  wire logic        flow_two_pulse_in,
  input  wire logic        heat_energy_inc_in,
  input  wire logic        cooling_energy_inc_in,
  input  wire logic        volume_inc_in,
  input  wire logic [2:0]  meter_type_in,
  input  wire logic        on_battery_in,
  input  wire logic [1:0]  nvm_saved_state_in,
  output logic             nvm_save_out,
  output logic      [1:0]  nvm_save_state_out,
  output logic             integration_tick_out,
  output logic             slot_one_first_output_out,
  output logic             slot_two_first_output_out,
  output logic             slot_one_second_output_out,
  output logic             slot_two_second_output_out
);
  // Elaboration checks on sizes the logic cannot serve
  if (CNT_W < 4 || CNT_W > 31) begin : g_bad_cnt
    $error("CNT_W must lie between 4 and 31");
  end
  if (W_5MS_CYC < 1 || W_3M9_CYC < 1 || W_10MS_CYC < 1 || INTEG_MAINS_CYC < 2) begin : g_bad_t
    $error("Timing counts must be at least one cycle");
  end

  logic [7:0]       func_code_q;
  logic [1:0]       res_code_q;
  logic [1:0]       cmd_state_q;
  logic [2:0]       meter_type_q;
  logic             strap_pending_q;
  logic [31:0]      integ_cnt_q;
  logic             tick_q;
  logic             flow_one_q;
  logic             flow_two_q;
  logic [1:0]       div_cnt_q;
  logic [2:0]       digit_step;
  logic [1:0]       src_sel [2];
  logic [CNT_W-1:0] batch_q [2];
  logic             trig [2];
  logic [31:0]      width_sel;
  logic             mode_div4;
  logic             mode_rep_both;
  logic             mode_rep_one;
  logic             mode_meter;
  logic             mode_ctrl;
  logic             flow_one_rise;
  logic             flow_two_rise;
  logic             code_ok;
  logic [1:0]       gen_pulse;
  logic [CNT_W-1:0] gen_owed [2];

  // Mode decode from the single function code
  assign mode_div4     = (func_code_q == mpoc_pkg::FC_DIV4_5MS)
                         || (func_code_q == mpoc_pkg::FC_DIV4_22MS);
  assign mode_rep_both = (func_code_q == mpoc_pkg::FC_REP_BOTH);
  assign mode_rep_one  = (func_code_q == mpoc_pkg::FC_REP_ONE);
  assign mode_ctrl     = (func_code_q == mpoc_pkg::FC_CONTROLLED);
  assign mode_meter    = !(mode_div4 || mode_rep_both || mode_rep_one || mode_ctrl);

  // Only listed codes are accepted; anything else leaves the code unchanged
  always_comb begin
    case (reg_wdata_in[7:0])
      mpoc_pkg::FC_DIV4_5MS, mpoc_pkg::FC_REP_BOTH, mpoc_pkg::FC_REP_ONE,
      mpoc_pkg::FC_DIV4_22MS, mpoc_pkg::FC_MC_250MS, mpoc_pkg::FC_MC_10MS,
      mpoc_pkg::FC_MC_32MS, mpoc_pkg::FC_MC_100MS, mpoc_pkg::FC_CONTROLLED: code_ok = 1'b1;
      default: code_ok = 1'b0;
    endcase
  end

  // Pulse width per code
  always_comb begin
    case (func_code_q)
      mpoc_pkg::FC_DIV4_5MS:  width_sel = 32'(W_5MS_CYC);
      mpoc_pkg::FC_DIV4_22MS: width_sel = 32'(W_22MS_CYC);
      mpoc_pkg::FC_REP_BOTH,
      mpoc_pkg::FC_REP_ONE:   width_sel = 32'(W_3M9_CYC);
      mpoc_pkg::FC_MC_10MS:   width_sel = 32'(W_10MS_CYC);
      mpoc_pkg::FC_MC_100MS:  width_sel = 32'(W_100MS_CYC);
      mpoc_pkg::FC_MC_250MS:  width_sel = 32'(W_250MS_CYC);
      default:                width_sel = 32'(W_32MS_CYC);
    endcase
  end

  // Function code and resolution registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      func_code_q <= mpoc_pkg::FC_RESET;
      res_code_q  <= mpoc_pkg::RES_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == mpoc_pkg::REG_FUNC_CODE && code_ok) begin
        func_code_q <= reg_wdata_in[7:0];
      end
      if (reg_addr_in == mpoc_pkg::REG_RESOLUTION) begin
        res_code_q <= reg_wdata_in[1:0];
      end
    end
  end

  // Meter type caught once after reset release; no register can alter it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_pending_q <= 1'b1;
      meter_type_q    <= 3'h0;
    end else if (strap_pending_q) begin
      strap_pending_q <= 1'b0;
      meter_type_q    <= meter_type_in;
    end
  end

  // Commanded pair states: restored from saved copy first, then host writes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_state_q        <= 2'h0;
      nvm_save_out       <= 1'b0;
      nvm_save_state_out <= 2'h0;
    end else begin
      nvm_save_out <= 1'b0;
      if (strap_pending_q) begin
        cmd_state_q <= nvm_saved_state_in;
      end else if (reg_wr_in && reg_addr_in == mpoc_pkg::REG_CMD_STATE && mode_ctrl) begin
        cmd_state_q <= reg_wdata_in[1:0];
        if (reg_wdata_in[1:0] != cmd_state_q) begin
          nvm_save_out       <= 1'b1;
          nvm_save_state_out <= reg_wdata_in[1:0];
        end
      end
    end
  end

  // Integration timer; the limit follows on_battery_in at once, in the interval under way
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      integ_cnt_q <= 32'h0000_0000;
      tick_q      <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (integ_cnt_q >= 32'(on_battery_in ? INTEG_BATT_CYC : INTEG_MAINS_CYC) - 32'h0000_0001)
      begin
        integ_cnt_q <= 32'h0000_0000;
        tick_q      <= 1'b1;
      end else begin
        integ_cnt_q <= integ_cnt_q + 32'h0000_0001;
      end
    end
  end
  assign integration_tick_out = tick_q;

  // Flow sensor edge detection and divide-by-four
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flow_one_q <= 1'b0;
      flow_two_q <= 1'b0;
      div_cnt_q  <= 2'h0;
    end else begin
      flow_one_q <= flow_one_pulse_in;
      flow_two_q <= flow_two_pulse_in;
      if (!mode_div4) begin
        div_cnt_q <= 2'h0;
      end else if (flow_one_rise) begin
        div_cnt_q <= div_cnt_q + 2'h1;
      end
    end
  end
  assign flow_one_rise = flow_one_pulse_in && !flow_one_q;
  assign flow_two_rise = flow_two_pulse_in && !flow_two_q;

  // Source increments scaled to the least displayed digit, one prescaler each
  genvar s;
  for (s = 0; s < 3; s++) begin : g_src
    logic [9:0] pre_q;
    logic       inc;
    logic [9:0] lim;
    assign inc = (s == 0) ? heat_energy_inc_in
               : (s == 1) ? cooling_energy_inc_in : volume_inc_in;
    assign lim = (res_code_q == 2'h0) ? 10'h000 : (res_code_q == 2'h1) ? 10'h009
               : (res_code_q == 2'h2) ? 10'h063 : 10'h3E7;
    assign digit_step[s] = inc && (pre_q >= lim);
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        pre_q <= 10'h000;
      end else if (inc) begin
        pre_q <= (pre_q >= lim) ? 10'h000 : pre_q + 10'h001;
      end
    end
  end

  // Source per pair from meter type
  always_comb begin
    case (meter_type_q)
      3'h3, 3'h6: begin
        src_sel[0] = mpoc_pkg::SRC_HEAT;
        src_sel[1] = mpoc_pkg::SRC_COOL;
      end
      3'h5: begin
        src_sel[0] = mpoc_pkg::SRC_COOL;
        src_sel[1] = mpoc_pkg::SRC_VOL;
      end
      3'h7: begin
        src_sel[0] = mpoc_pkg::SRC_VOL;
        src_sel[1] = mpoc_pkg::SRC_VOL;
      end
      default: begin
        src_sel[0] = mpoc_pkg::SRC_HEAT;
        src_sel[1] = mpoc_pkg::SRC_VOL;
      end
    endcase
  end

  // Transmitter triggers per pair
  assign trig[0] = (mode_div4 && flow_one_rise && div_cnt_q == 2'(mpoc_pkg::DIV_BY_FOUR - 1))
                   || ((mode_rep_both || mode_rep_one) && flow_one_rise);
  assign trig[1] = mode_rep_both && flow_two_rise;

  // Per pair: batch gathering, emitter, and a shared drive for both members
  genvar p;
  for (p = 0; p < 2; p++) begin : g_pair
    mpoc_pair_if #(.CNT_W(CNT_W)) pif ();
    logic step;
    assign step = mode_meter && digit_step[src_sel[p]];

    // Batch is handed over at each integration, a same-cycle step starts the next
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        batch_q[p] <= '0;
      end else if (!mode_meter) begin
        batch_q[p] <= '0;
      end else if (tick_q) begin
        batch_q[p] <= {{(CNT_W-1){1'b0}}, step};
      end else if (step && batch_q[p] != '1) begin
        batch_q[p] <= batch_q[p] + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end

    assign pif.add_valid = mode_meter ? tick_q : trig[p];
    assign pif.add_count = mode_meter ? batch_q[p] : {{(CNT_W-1){1'b0}}, 1'b1};
    assign pif.width_cyc = width_sel;
    assign pif.clear     = mode_ctrl || (mode_rep_one && p == 1);
    assign gen_pulse[p]  = pif.pulse;
    assign gen_owed[p]   = pif.owed;

    mpoc_pair_gen #(.CNT_W(CNT_W)) u_gen (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .port    (pif.gen)
    );
  end

  // Output pins: each pair drives its slot one and slot two member alike
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      slot_one_first_output_out  <= 1'b0;
      slot_two_first_output_out  <= 1'b0;
      slot_one_second_output_out <= 1'b0;
      slot_two_second_output_out <= 1'b0;
    end else begin
      slot_one_first_output_out  <= mode_ctrl ? cmd_state_q[0] : gen_pulse[0];
      slot_two_first_output_out  <= mode_ctrl ? cmd_state_q[0] : gen_pulse[0];
      slot_one_second_output_out <= mode_ctrl ? cmd_state_q[1] : gen_pulse[1];
      slot_two_second_output_out <= mode_ctrl ? cmd_state_q[1] : gen_pulse[1];
    end
  end

  // Read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        mpoc_pkg::REG_FUNC_CODE:  reg_rdata_out <= {24'h00_0000, func_code_q};
        mpoc_pkg::REG_RESOLUTION: reg_rdata_out <= {30'h0000_0000, res_code_q};
        mpoc_pkg::REG_CMD_STATE:  reg_rdata_out <= {30'h0000_0000, cmd_state_q};
        mpoc_pkg::REG_STATUS: begin
          reg_rdata_out <= 32'h0000_0000;
          reg_rdata_out[mpoc_pkg::ST_OUT_ONE] <= slot_one_first_output_out;
          reg_rdata_out[mpoc_pkg::ST_OUT_TWO] <= slot_one_second_output_out;
          reg_rdata_out[mpoc_pkg::ST_BATTERY] <= on_battery_in;
          reg_rdata_out[mpoc_pkg::ST_TYPE_LSB +: 3] <= meter_type_q;
        end
        mpoc_pkg::REG_OWED_ONE:   reg_rdata_out <= 32'(gen_owed[0]);
        mpoc_pkg::REG_OWED_TWO:   reg_rdata_out <= 32'(gen_owed[1]);
        default:                  reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end
endmodule

/* File: testbench/mpoc_top_assertions.sv */
// Port-level assertions for the meter pulse output controller
`timescale 1ns/1ps
module mpoc_top_assertions #(
  parameter int W_5MS_CYC       = 4,
  parameter int W_22MS_CYC      = 6,
  parameter int W_3M9_CYC       = 3,
  parameter int W_10MS_CYC      = 5,
  parameter int W_32MS_CYC      = 7,
  parameter int W_100MS_CYC     = 9,
  parameter int W_250MS_CYC     = 11,
  parameter int INTEG_MAINS_CYC = 200,
  parameter int INTEG_BATT_CYC  = 800
) (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        on_battery_in,
  input wire logic        nvm_save_out,
  input wire logic [1:0]  nvm_save_state_out,
  input wire logic        integration_tick_out,
  input wire logic        slot_one_first_output_out,
  input wire logic        slot_two_first_output_out,
  input wire logic        slot_one_second_output_out,
  input wire logic        slot_two_second_output_out
);
  logic [7:0]  fc_q;
  logic [31:0] hi_q, lo_q, gap_q;
  logic        seen_q, any_b_q, all_b_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Width per code; zero where the block makes no pulses of its own
  function automatic int wid(input logic [7:0] c);
    case (c)
      8'h49: return W_5MS_CYC;
      8'h53: return W_22MS_CYC;
      8'h50, 8'h52: return W_3M9_CYC;
      8'h5E: return W_10MS_CYC;
      8'h5F: return W_32MS_CYC;
      8'h60: return W_100MS_CYC;
      8'h5D: return W_250MS_CYC;
      default: return 0;
    endcase
  endfunction
  // Shadow of the function code; unlisted codes are dropped
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fc_q <= 8'h5F;
    end else if (reg_wr_in && reg_addr_in == 4'h0 &&
                 (wid(reg_wdata_in[7:0]) != 0 || reg_wdata_in[7:0] == 8'h63)) begin
      fc_q <= reg_wdata_in[7:0];
    end
  end
  // Run lengths, tick spacing and battery history per interval
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {hi_q, lo_q, gap_q}        <= '0;
      {seen_q, any_b_q, all_b_q} <= 3'h0;
    end else begin
      hi_q    <= slot_one_first_output_out ? hi_q + 1 : 32'h0000_0000;
      lo_q    <= slot_one_first_output_out ? 32'h0000_0000 : lo_q + 1;
      gap_q   <= integration_tick_out ? 32'h0000_0001 : gap_q + 1;
      seen_q  <= seen_q | integration_tick_out;
      any_b_q <= integration_tick_out ? on_battery_in : any_b_q | on_battery_in;
      all_b_q <= integration_tick_out ? on_battery_in : all_b_q & on_battery_in;
    end
  end
  sequence s_pins_match;
    slot_one_first_output_out == nvm_save_state_out[0] &&
    slot_one_second_output_out == nvm_save_state_out[1];
  endsequence
  property p_pair_one_same;
    slot_one_first_output_out == slot_two_first_output_out;
  endproperty
  a_pair_one_same: assert property (p_pair_one_same) else $error("pair one split");
  property p_pair_two_same;
    slot_one_second_output_out == slot_two_second_output_out;
  endproperty
  a_pair_two_same: assert property (p_pair_two_same) else $error("pair two split");
  property p_tick_one;
    integration_tick_out |=> !integration_tick_out;
  endproperty
  a_tick_one: assert property (p_tick_one) else $error("tick too long");
  property p_mains_gap;
    integration_tick_out && seen_q && !any_b_q |-> gap_q == INTEG_MAINS_CYC;
  endproperty
  a_mains_gap: assert property (p_mains_gap) else $error("mains interval wrong");
  property p_batt_gap;
    integration_tick_out && seen_q && all_b_q |-> gap_q == INTEG_BATT_CYC;
  endproperty
  a_batt_gap: assert property (p_batt_gap) else $error("battery interval wrong");
  property p_width_one;
    $fell(slot_one_first_output_out) && wid(fc_q) != 0 |-> hi_q == wid(fc_q);
  endproperty
  a_width_one: assert property (p_width_one) else $error("pulse width wrong");
  property p_gap_one;
    $rose(slot_one_first_output_out) && wid(fc_q) != 0 |-> lo_q >= wid(fc_q);
  endproperty
  a_gap_one: assert property (p_gap_one) else $error("pulse gap short");
  property p_ctl_follow;
    nvm_save_out |-> ##[0:2] s_pins_match;
  endproperty
  a_ctl_follow: assert property (p_ctl_follow) else $error("pins miss command");
  property p_idle_two;
    fc_q == 8'h52 && $past(fc_q, 3) == 8'h52 |-> !slot_one_second_output_out;
  endproperty
  a_idle_two: assert property (p_idle_two) else $error("pair two active");
endmodule
bind mpoc_top mpoc_top_assertions #(
  .W_5MS_CYC(W_5MS_CYC), .W_22MS_CYC(W_22MS_CYC), .W_3M9_CYC(W_3M9_CYC),
  .W_10MS_CYC(W_10MS_CYC), .W_32MS_CYC(W_32MS_CYC), .W_100MS_CYC(W_100MS_CYC),
  .W_250MS_CYC(W_250MS_CYC), .INTEG_MAINS_CYC(INTEG_MAINS_CYC), .INTEG_BATT_CYC(INTEG_BATT_CYC)
) u_chk (.*);

/* File: testbench/mpoc_pulse_counter.sv */
// Far-side counter that tallies each closing of the two output pairs
`timescale 1ns/1ps
module mpoc_pulse_counter (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        pair_one_in,
  input  wire logic        pair_two_in,
  output logic      [31:0] count_one_out,
  output logic      [31:0] count_two_out
);
  logic one_q, two_q;
  // A closed switch reads high; each new closing is one counted pulse
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {one_q, two_q} <= 2'h0;
      count_one_out  <= 32'h0000_0000;
      count_two_out  <= 32'h0000_0000;
    end else begin
      {one_q, two_q} <= {pair_one_in, pair_two_in};
      count_one_out  <= count_one_out + {31'h0, pair_one_in & ~one_q};
      count_two_out  <= count_two_out + {31'h0, pair_two_in & ~two_q};
    end
  end
endmodule

/* File: testbench/meter_pulse_output_controller_tb_top.sv */
// Self-checking bench for the meter pulse output controller
`timescale 1ns/1ps
module meter_pulse_output_controller_tb_top;
  logic        clk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, cnt1, cnt2, b1, b2;
  logic        flow_one_pulse_in = 1'b0, flow_two_pulse_in = 1'b0, on_battery_in = 1'b0;
  logic        heat_energy_inc_in = 1'b0, cooling_energy_inc_in = 1'b0, volume_inc_in = 1'b0;
  logic [2:0]  meter_type_in = 3'h5;
  logic [1:0]  nvm_saved_state_in = 2'h2, nvm_save_state_out;
  logic        nvm_save_out, integration_tick_out, slot_one_first_output_out;
  logic        slot_two_first_output_out, slot_one_second_output_out;
  logic        slot_two_second_output_out;
  int          n_fail = 0, check_count = 0, n;
  // Transfer modes first, then meter-count codes, resolutions and carry cases
  logic [7:0]  fcode [4] = '{8'h50, 8'h52, 8'h49, 8'h53};
  int          fnum [4] = '{2, 2, 8, 8}, fe2 [4] = '{2, 0, 0, 0};
  logic [7:0]  mcode [5] = '{8'h5E, 8'h5F, 8'h60, 8'h5D, 8'h5E};
  logic [1:0]  mres [5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
  int          mc [5] = '{3, 3, 1, 12, 10}, mv [5] = '{2, 2, 2, 0, 20};
  int          me1 [5] = '{3, 3, 1, 12, 1}, me2 [5] = '{2, 2, 2, 0, 2};
  // Short widths keep the run brief; expectations use the same figures
  localparam int WD [7] = '{4, 6, 3, 5, 7, 9, 11};
  localparam int TM = 200, TB = 800;
  mpoc_top #(.W_5MS_CYC(WD[0]), .W_22MS_CYC(WD[1]), .W_3M9_CYC(WD[2]), .W_10MS_CYC(WD[3]),
    .W_32MS_CYC(WD[4]), .W_100MS_CYC(WD[5]), .W_250MS_CYC(WD[6]), .INTEG_MAINS_CYC(TM),
    .INTEG_BATT_CYC(TB)) uut (.*);
  mpoc_pulse_counter u_far (.clk_in, .rstn_in, .pair_one_in(slot_one_first_output_out),
    .pair_two_in(slot_one_second_output_out), .count_one_out(cnt1), .count_two_out(cnt2));
  always #5 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, d};
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    {reg_rd_in, reg_addr_in} <= {1'b1, a};
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, e);
  endtask
  task automatic fl(input int k);
    repeat (k) begin
      @(posedge clk_in);
      {flow_one_pulse_in, flow_two_pulse_in} <= 2'h3;
      repeat (2) @(posedge clk_in);
      {flow_one_pulse_in, flow_two_pulse_in} <= 2'h0;
      @(posedge clk_in);
    end
  endtask
  // Heat steps always go out; meter type five must never forward them
  task automatic inc(input int nc, input int nv);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_in);
      {cooling_energy_inc_in, volume_inc_in, heat_energy_inc_in} <= {i < nc, i < nv, i < 3};
      @(posedge clk_in);
      {cooling_energy_inc_in, volume_inc_in, heat_energy_inc_in} <= 3'h0;
    end
  endtask
  task automatic wt(output int k);
    k = 0;
    do begin
      @(posedge clk_in);
      #1;
      k++;
    end while (!integration_tick_out && k < 2000);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    #300_000;
    n_fail++;
    results;
  end
  initial begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    {meter_type_in, nvm_saved_state_in} <= {3'h7, 2'h1};
    rd(4'h0, 32'h0000_005F);
    rd(4'h1, 32'h0000_0000);
    wr(4'h3, 32'hFFFF_FFFF);
    rd(4'h3, 32'h0000_0050);
    rd(4'hF, 32'h0000_0000);
    wr(4'h0, 32'h0000_0063);
    repeat (4) @(posedge clk_in);
    rd(4'h3, 32'h0000_0052);
    rd(4'h2, 32'h0000_0002);
    wr(4'h2, 32'h0000_0001);
    fl(3);
    rd(4'h3, 32'h0000_0051);
    chk({30'h0, nvm_save_state_out}, 32'h0000_0001);
    wr(4'h0, 32'h0000_0011);
    rd(4'h0, 32'h0000_0063);
    wr(4'h2, 32'h0000_0000);
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {24'h00_0000, fcode[i]});
      {b1, b2} = {cnt1, cnt2};
      fl(fnum[i]);
      repeat (60) @(posedge clk_in);
      chk(cnt1 - b1, 32'h0000_0002);
      chk(cnt2 - b2, fe2[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, {24'h00_0000, mcode[i]});
      wr(4'h1, {30'h0, mres[i]});
      wt(n);
      {b1, b2} = {cnt1, cnt2};
      inc(mc[i], mv[i]);
      chk(cnt1 - b1, 32'h0000_0000);
      wt(n);
      repeat (400) @(posedge clk_in);
      chk(cnt1 - b1, me1[i]);
      chk(cnt2 - b2, me2[i]);
    end
    on_battery_in <= 1'b1;
    rd(4'h3, 32'h0000_0054);
    wt(n);
    wt(n);
    chk(n, TB);
    on_battery_in <= 1'b0;
    wt(n);
    wt(n);
    chk(n, TM);
    results;
  end
endmodule
